// File: logic/difd_pkg.sv
// Package of codes, modes and widths for the input function decoder
package difd_pkg;
    // Number of digital inputs and widths
    localparam int NUM_INPUTS = 8;
    localparam int CODE_W = 8;
    localparam int SPEED_W = 16;
    localparam int COUNT_W = 32;
    localparam int GAIN_W = 16;
    localparam int SETTING_W = 8;

    // Input function codes
    localparam logic [7:0] FN_DRIVE_ENABLE = 8'h01;
    localparam logic [7:0] FN_ALARM_CLEAR = 8'h02;
    localparam logic [7:0] FN_GAIN_BOOST = 8'h03;
    localparam logic [7:0] FN_COUNT_CLEAR = 8'h04;
    localparam logic [7:0] FN_ZERO_LOCK = 8'h05;
    localparam logic [7:0] FN_DIR_INVERT = 8'h06;
    localparam logic [7:0] FN_TORQUE_LIMIT = 8'h09;
    localparam logic [7:0] FN_SPEED_LIMIT = 8'h10;

    // Setting values
    localparam logic [7:0] GAIN_COND_INPUT = 8'h01;
    localparam logic [7:0] CLEAR_MODE_LEVEL = 8'h00;

    // Reset values
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [7:0] FAULT_RESET = 8'h00;

    // Control modes
    typedef enum logic [1:0] {
        DIFD_MODE_PT = 2'b00,
        DIFD_MODE_S = 2'b01,
        DIFD_MODE_T = 2'b10,
        DIFD_MODE_OTHER = 2'b11
    } difd_mode_t;
endpackage

// File: logic/difd_code_match.sv
// One input line: passes its code through and finds its rising edge
`timescale 1ns/100ps
module difd_code_match (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Input line and its function code
    input wire logic i_level,
    input wire logic [7:0] i_code,
    // Decoded function levels and edge
    output logic [7:0] o_code,
    output logic o_active,
    output logic o_rise
);
    logic prev;

    // Previous level for the edge detector
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= i_level;
        end
    end

    // Decode outputs
    assign o_code = i_code;
    assign o_active = i_level;
    assign o_rise = i_level & ~prev;
endmodule // difd_code_match

// File: logic/difd_decoder.sv
// Top of the input function decoder
`timescale 1ns/100ps
// Operation
// - Code 0x01 held active enables the drive in all modes
// - Code 0x02 rising edge clears clearable faults; others stay set
// - Code 0x03 with condition setting 1 boosts gain in PT and S
// - Code 0x04 in PT applies clear mode; mode 0 holds count zero
// - Code 0x05 in S below threshold locks motor position
// - Code 0x06 active inverts command direction in S and T
// - Code 0x09 in S and PT applies torque limit
// - Code 0x10 in T applies speed limit
module difd_decoder (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Digital input lines and their function codes
    input wire logic [7:0] i_input_lines,
    input wire logic [63:0] i_input_codes,
    // Settings and mode
    input wire logic [1:0] i_control_mode,
    input wire logic [7:0] i_gain_switch_condition_setting,
    input wire logic [7:0] i_pulse_clear_mode_setting,
    input wire logic [15:0] i_zero_speed_threshold_setting,
    input wire logic [15:0] i_gain_switch_rate,
    input wire logic [15:0] i_base_gain,
    // Drive state
    input wire logic [15:0] i_motor_speed,
    input wire logic [31:0] i_pulse_count,
    input wire logic [7:0] i_fault_set,
    input wire logic [7:0] i_fault_clearable,
    // Decoded behaviour
    output logic o_drive_enable,
    output logic [7:0] o_faults,
    output logic [15:0] o_loop_gain,
    output logic o_gain_boost,
    output logic [31:0] o_pulse_count,
    output logic o_position_lock,
    output logic o_direction_invert,
    output logic o_torque_limit_enable,
    output logic o_speed_limit_enable
);
    logic [7:0] code [8];
    logic [7:0] act;
    logic [7:0] rise;
    logic [7:0] hit_en, hit_clr, hit_gain, hit_cnt;
    logic [7:0] hit_lock, hit_inv, hit_tlim, hit_slim;

    // One matcher per input line
    genvar g;
    generate
        for (g = 0; g < difd_pkg::NUM_INPUTS; g++) begin : g_in
            difd_code_match u_match (
                .i_core_clk(i_core_clk),
                .i_rst_n(i_rst_n),
                .i_level(i_input_lines[g]),
                .i_code(i_input_codes[g*8 +: 8]),
                .o_code(code[g]),
                .o_active(act[g]),
                .o_rise(rise[g])
            );
            // Only listed codes match; others fall through
            assign hit_en[g] = act[g] && code[g] == difd_pkg::FN_DRIVE_ENABLE;
            assign hit_clr[g] = rise[g] && code[g] == difd_pkg::FN_ALARM_CLEAR;
            assign hit_gain[g] = act[g] && code[g] == difd_pkg::FN_GAIN_BOOST;
            assign hit_cnt[g] = act[g] && code[g] == difd_pkg::FN_COUNT_CLEAR;
            assign hit_lock[g] = act[g] && code[g] == difd_pkg::FN_ZERO_LOCK;
            assign hit_inv[g] = act[g] && code[g] == difd_pkg::FN_DIR_INVERT;
            assign hit_tlim[g] = act[g]
                && code[g] == difd_pkg::FN_TORQUE_LIMIT;
            assign hit_slim[g] = act[g]
                && code[g] == difd_pkg::FN_SPEED_LIMIT;
        end
    endgenerate

    // Mode decode
    wire mode_pt = i_control_mode == difd_pkg::DIFD_MODE_PT;
    wire mode_s = i_control_mode == difd_pkg::DIFD_MODE_S;
    wire mode_t = i_control_mode == difd_pkg::DIFD_MODE_T;

    // Function conditions
    wire next_enable = |hit_en;
    wire alarm_clear = |hit_clr;
    wire next_boost = (|hit_gain) && (mode_pt || mode_s)
        && i_gain_switch_condition_setting
        == difd_pkg::GAIN_COND_INPUT;
    wire count_hold = (|hit_cnt) && mode_pt
        && i_pulse_clear_mode_setting
        == difd_pkg::CLEAR_MODE_LEVEL;
    wire next_lock = (|hit_lock) && mode_s
        && i_motor_speed < i_zero_speed_threshold_setting;
    wire next_inv = (|hit_inv) && (mode_s || mode_t);
    wire next_tlim = (|hit_tlim) && (mode_s || mode_pt);
    wire next_slim = (|hit_slim) && mode_t;
    wire [31:0] boosted = 32'(i_base_gain) * 32'(i_gain_switch_rate);
    wire [15:0] next_gain = next_boost ? boosted[15:0] : i_base_gain;
    // New faults win over a clear in the same cycle
    wire [7:0] next_faults = alarm_clear
        ? ((o_faults & ~i_fault_clearable) | i_fault_set)
        : (o_faults | i_fault_set);
    wire [31:0] next_count = count_hold ? difd_pkg::COUNT_RESET
        : i_pulse_count;

    // Registered outputs
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drive_enable <= 1'b0;
            o_faults <= difd_pkg::FAULT_RESET;
            o_loop_gain <= difd_pkg::GAIN_RESET;
            o_gain_boost <= 1'b0;
            o_pulse_count <= difd_pkg::COUNT_RESET;
            o_position_lock <= 1'b0;
            o_direction_invert <= 1'b0;
            o_torque_limit_enable <= 1'b0;
            o_speed_limit_enable <= 1'b0;
        end else begin
            o_drive_enable <= next_enable;
            o_faults <= next_faults;
            o_loop_gain <= next_gain;
            o_gain_boost <= next_boost;
            o_pulse_count <= next_count;
            o_position_lock <= next_lock;
            o_direction_invert <= next_inv;
            o_torque_limit_enable <= next_tlim;
            o_speed_limit_enable <= next_slim;
        end
    end

    // Checks: each output is judged one edge after the inputs it follows
    // Request seen on some enable line this cycle
    sequence s_en_seen;
        next_enable;
    endsequence

    // A clear edge and a new fault on bit 0 in the same cycle
    sequence s_clear_and_set;
        alarm_clear && i_fault_set[0];
    endsequence

    // Lines unchanged since the last edge, with reset already released
    sequence s_lines_still;
        $past(i_rst_n) && i_input_lines == $past(i_input_lines);
    endsequence

    // Drive enable tracks the enable lines with one cycle of latency
    a_enable_follows: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) s_en_seen |=> o_drive_enable)
        else $error("drive enable not raised");
    a_enable_drops: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) !next_enable |=> !o_drive_enable)
        else $error("drive enable stuck");

    // Fault bits: set by a pulse, cleared only by an edge where clearable
    a_clear_fault: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) alarm_clear && !i_fault_set[0]
        && i_fault_clearable[0] |=> !o_faults[0])
        else $error("clearable fault kept");
    a_fault_keeps: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_faults[1] && !i_fault_clearable[1]
        |=> o_faults[1])
        else $error("fixed fault cleared");
    a_set_wins: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) s_clear_and_set |=> o_faults[0])
        else $error("clear beat a new fault");
    a_fault_sticky: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) !alarm_clear
        |=> o_faults == ($past(o_faults) | $past(i_fault_set)))
        else $error("fault dropped without clear");
    a_clear_once: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) s_lines_still |-> !alarm_clear)
        else $error("clear repeated on a held line");

    // Gain: the product while boosting, the base value otherwise
    a_gain_boost: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) next_boost
        |=> o_loop_gain
        == 16'($past(i_base_gain) * $past(i_gain_switch_rate)))
        else $error("gain not boosted");
    a_gain_base: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) !next_boost
        |=> o_loop_gain == $past(i_base_gain))
        else $error("gain changed without boost");
    a_boost_mode: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_gain_boost
        |-> $past(mode_pt || mode_s)
        && $past(i_gain_switch_condition_setting)
        == difd_pkg::GAIN_COND_INPUT)
        else $error("boost outside its modes");

    // Pulse count: zero while held, the live count otherwise
    a_count_zero: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) count_hold
        |=> o_pulse_count == difd_pkg::COUNT_RESET)
        else $error("count not held at zero");
    a_count_pass: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) !count_hold
        |=> o_pulse_count == $past(i_pulse_count))
        else $error("count not passed through");
    a_count_mode: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) $past(i_rst_n)
        && o_pulse_count != $past(i_pulse_count)
        |-> $past(mode_pt))
        else $error("count cleared outside position mode");

    // Lock, invert and limits appear only in their own modes
    a_lock_mode: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_position_lock |-> $past(mode_s))
        else $error("lock outside speed mode");
    a_lock_speed: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_position_lock
        |-> $past(i_motor_speed) < $past(i_zero_speed_threshold_setting))
        else $error("lock above speed threshold");
    a_invert_mode: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_direction_invert
        |-> $past(mode_s || mode_t))
        else $error("invert in wrong mode");
    a_tlim_mode: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_torque_limit_enable
        |-> $past(mode_s || mode_pt))
        else $error("torque limit outside its modes");
    a_slim_mode: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n) o_speed_limit_enable |-> $past(mode_t))
        else $error("speed limit outside torque mode");
endmodule // difd_decoder

// File: bench/difd_partner.sv
// Controller model that drives the digital input lines and their codes
`timescale 1ns/100ps
module difd_partner (
    // Line levels and per-line function codes
    output logic [7:0] o_lines,
    output logic [63:0] o_codes
);
    // All lines idle and unassigned at start
    initial begin
        o_lines = 8'h00;
        o_codes = 64'h0000_0000_0000_0000;
    end
    // Assign a code and a level to one line; called just after a fall
    task automatic drive(input int idx, input logic [7:0] code,
                         input logic lvl);
        o_codes[idx*8 +: 8] = code;
        o_lines[idx] = lvl;
    endtask
endmodule // difd_partner

// File: bench/difd_decoder_tb.sv
// Self-checking bench for the input function decoder
`timescale 1ns/100ps
module difd_decoder_tb;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] cond = 8'h00, clr = 8'h00, fset = 8'h00, fclr = 8'h00;
    logic [15:0] thr = 16'h0000, rate = 16'h0000, base = 16'h0000;
    logic [15:0] speed = 16'h0000;
    logic [31:0] cnt = 32'h0000_0000, pcnt;
    logic [7:0] lines, faults;
    logic [63:0] codes;
    logic [15:0] gain;
    logic den, boost, lock, inv, tlim, slim;
    int fails = 0, num_checks = 0, cycles = 0;
    // Clock generation
    always #10 i_core_clk = ~i_core_clk;
    difd_partner i_difd_partner (.o_lines(lines), .o_codes(codes));
    difd_decoder i_difd_decoder (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_input_lines(lines), .i_input_codes(codes),
        .i_control_mode(mode), .i_gain_switch_condition_setting(cond),
        .i_pulse_clear_mode_setting(clr),
        .i_zero_speed_threshold_setting(thr), .i_gain_switch_rate(rate),
        .i_base_gain(base), .i_motor_speed(speed), .i_pulse_count(cnt),
        .i_fault_set(fset), .i_fault_clearable(fclr),
        .o_drive_enable(den), .o_faults(faults), .o_loop_gain(gain),
        .o_gain_boost(boost), .o_pulse_count(pcnt), .o_position_lock(lock),
        .o_direction_invert(inv), .o_torque_limit_enable(tlim),
        .o_speed_limit_enable(slim));
    // Print counts and verdict, then end the run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Compare one result value
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Let one rising edge take the inputs, look at the next fall
    task automatic cyc;
        @(negedge i_core_clk);
    endtask
    // Hang guard
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            stop_test;
        end
    end
    // Test sequence
    initial begin
        repeat (2) @(negedge i_core_clk);
        i_rst_n = 1'b1;
        mode = 2'h2;
        i_difd_partner.drive(0, difd_pkg::FN_DRIVE_ENABLE, 1'b1);
        cyc;
        chk("enable", 1, den);
        i_difd_partner.drive(0, difd_pkg::FN_DRIVE_ENABLE, 1'b0);
        cyc;
        chk("enable off", 0, den);
        i_difd_partner.drive(0, 8'h07, 1'b1);
        cyc;
        chk("reserved", 0, {faults, den, boost, inv, tlim, slim});
        fset = 8'h03;
        fclr = 8'h01;
        cyc;
        fset = 8'h00;
        cyc;
        chk("faults set", 3, faults);
        i_difd_partner.drive(1, difd_pkg::FN_ALARM_CLEAR, 1'b1);
        cyc;
        chk("clear edge", 2, faults);
        fset = 8'h01;
        cyc;
        fset = 8'h00;
        cyc;
        chk("held no clear", 3, faults);
        i_difd_partner.drive(1, difd_pkg::FN_ALARM_CLEAR, 1'b0);
        cyc;
        i_difd_partner.drive(1, difd_pkg::FN_ALARM_CLEAR, 1'b1);
        cyc;
        chk("second edge", 2, faults);
        // A clear edge and a new fault in one cycle: the fault stays
        i_difd_partner.drive(1, difd_pkg::FN_ALARM_CLEAR, 1'b0);
        cyc;
        i_difd_partner.drive(1, difd_pkg::FN_ALARM_CLEAR, 1'b1);
        fset = 8'h01;
        cyc;
        fset = 8'h00;
        chk("set wins", 3, faults);
        base = 16'h0003;
        rate = 16'h0005;
        cond = 8'h01;
        clr = 8'h00;
        cnt = 32'h1234_5678;
        thr = 16'h0014;
        speed = 16'h0014;
        i_difd_partner.drive(2, difd_pkg::FN_GAIN_BOOST, 1'b1);
        i_difd_partner.drive(3, difd_pkg::FN_COUNT_CLEAR, 1'b1);
        i_difd_partner.drive(4, difd_pkg::FN_ZERO_LOCK, 1'b1);
        mode = 2'h1;
        cyc;
        chk("lock at threshold", 0, lock);
        // Position mode with both settings off: no boost, no clear
        cond = 8'h00;
        clr = 8'h01;
        mode = 2'h0;
        cyc;
        chk("gain cond off", 3, gain);
        chk("count mode 1", 32'h1234_5678, pcnt);
        cond = 8'h01;
        clr = 8'h00;
        speed = 16'h0013;
        i_difd_partner.drive(5, difd_pkg::FN_DIR_INVERT, 1'b1);
        i_difd_partner.drive(6, difd_pkg::FN_TORQUE_LIMIT, 1'b1);
        i_difd_partner.drive(7, difd_pkg::FN_SPEED_LIMIT, 1'b1);
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            cyc;
            chk("boost", m <= 1, boost);
            chk("gain", (m <= 1) ? 15 : 3, gain);
            chk("count", (m == 0) ? 0 : 32'h1234_5678, pcnt);
            chk("lock", m == 1, lock);
            chk("invert", m == 1 || m == 2, inv);
            chk("torque limit", m <= 1, tlim);
            chk("speed limit", m == 2, slim);
        end
        // Reset in mid-run: outputs clear, requests act at the first edge
        i_rst_n = 1'b0;
        cyc;
        chk("reset flags", 0, {den, boost, lock, inv, tlim, slim});
        chk("reset faults", 0, faults);
        chk("reset gain", 0, gain);
        chk("reset count", 0, pcnt);
        mode = 2'h1;
        cyc;
        i_rst_n = 1'b1;
        cyc;
        chk("lock after reset", 1, lock);
        chk("gain after reset", 15, gain);
        chk("faults after reset", 0, faults);
        stop_test;
    end
endmodule // difd_decoder_tb
